// File: verilog/debug_trace_port.v
// How it works
// R1 - test-select level caught at reset routes shared pins to scan or debug logic
// R2 - active-low test reset clears scan logic at once, without the test clock
// R3 - mode select sampled on each test clock rise steps the controller
// R4 - test data in sampled on each test clock rise
// R5 - test data out driven only in shift states, updated on test clock fall
// R6 - test data out released in every other controller state
// R7 - serial clock accepted only after two equal consecutive samples
// R8 - debugger keeps serial clock at most one fifth of trace clock
// R9 - on synchronized serial clock rise, sample serial input, shift serial output
// R10 - serial output comes from a register, a fixed delay after validation
// R11 - breakpoint with disable clear halts after instruction, status shows 0xf
// R12 - breakpoint with disable set raises a debug interrupt instead
// R13 - trace clock rises in the middle of each valid status word
// R14 - trace-clock-disable freezes trace outputs; triggers still work
// R15 - trace clock starts only at first nonzero reset status 0xc, 0xd or 0xf
// R16 - status outputs follow the core on the processor clock
// R17 - combined status output is the AND of the four status bits
// R18 - debug data outputs carry captured data and breakpoint status; code carries the core debug data only, no breakpoint status
// R19 - debugger may time sampling of debug data by the system clock
`include "debug_trace_port_defines.vh"
`default_nettype none

module debug_trace_port (
  // clock and reset
  input  wire       i_ref_clk,
  input  wire       i_rst_b,
  // mode strap
  input  wire       i_scan_select,
  // boundary-scan pins
  input  wire       i_test_rst_b,
  input  wire       i_test_clk,
  input  wire       i_test_mode,
  input  wire       i_test_din,
  output reg        o_test_dout,
  output reg        o_test_dout_oe,
  // background debug serial pins
  input  wire       i_dev_serial_clock,
  input  wire       i_dev_serial_in,
  output reg        o_dev_serial_out,
  // core side
  input  wire       i_breakpoint_request,
  input  wire       i_instr_done,
  input  wire [3:0] i_core_status,
  input  wire [3:0] i_core_debug_data,
  input  wire       i_core_data_valid,
  output wire       o_core_data_ready,
  output reg        o_halt_req,
  output reg        o_debug_irq,
  // debug configuration
  input  wire       i_breakpoint_disable,
  input  wire       i_trace_clock_disable,
  // serial packet to and from the core
  output reg [16:0] o_rx_packet,
  output reg        o_rx_valid,
  input  wire [16:0] i_tx_packet,
  // trace pins
  output reg        o_trace_clock,
  output reg  [3:0] o_proc_status_out,
  output reg  [3:0] o_debug_data_out,
  output wire       o_all_status_and,
  output wire       o_system_clock_out,
  output reg        o_scan_mode
);

  // ---------------- mode strap ----------------
  reg  strap_meta_q;
  reg  strap_sync_q;
  reg  strap_taken_q;
  reg  [1:0] strap_cnt_q;

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_meta_q  <= 1'b0;
      strap_sync_q  <= 1'b0;
      strap_taken_q <= 1'b0;
      strap_cnt_q   <= 2'h0;
      o_scan_mode   <= 1'b0;
    end else begin
      strap_meta_q <= i_scan_select;
      strap_sync_q <= strap_meta_q;
      if (strap_cnt_q != `STRAP_WAIT) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
      // wait for the synchroniser to hold the pin, then latch once
      if (!strap_taken_q && (strap_cnt_q == `STRAP_WAIT)) begin
        o_scan_mode   <= strap_sync_q; // R1
        strap_taken_q <= 1'b1;
      end
    end
  end

  // ---------------- scan controller (test clock domain) ----------------
  reg  [3:0] tap_q;
  reg  [3:0] tap_d;
  reg  [3:0] ir_q;
  reg  [3:0] ir_sh_q;
  reg        bypass_q;
  reg  [3:0] idcode_sh_q;
  wire       tms;
  wire       shift_state;
  reg        tdo_bit;

  assign tms = i_test_mode;

  always @* begin
    case (tap_q)
      `TAP_RESET:    tap_d = tms ? `TAP_RESET   : `TAP_IDLE;
      `TAP_IDLE:     tap_d = tms ? `TAP_SEL_DR  : `TAP_IDLE;
      `TAP_SEL_DR:   tap_d = tms ? `TAP_SEL_IR  : `TAP_CAP_DR;
      `TAP_CAP_DR:   tap_d = tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_SHIFT_DR: tap_d = tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_EXIT1_DR: tap_d = tms ? `TAP_UPD_DR  : `TAP_PAUSE_DR;
      `TAP_PAUSE_DR: tap_d = tms ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
      `TAP_EXIT2_DR: tap_d = tms ? `TAP_UPD_DR  : `TAP_SHIFT_DR;
      `TAP_UPD_DR:   tap_d = tms ? `TAP_SEL_DR  : `TAP_IDLE;
      `TAP_SEL_IR:   tap_d = tms ? `TAP_RESET   : `TAP_CAP_IR;
      `TAP_CAP_IR:   tap_d = tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_SHIFT_IR: tap_d = tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_EXIT1_IR: tap_d = tms ? `TAP_UPD_IR  : `TAP_PAUSE_IR;
      `TAP_PAUSE_IR: tap_d = tms ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
      `TAP_EXIT2_IR: tap_d = tms ? `TAP_UPD_IR  : `TAP_SHIFT_IR;
      `TAP_UPD_IR:   tap_d = tms ? `TAP_SEL_DR  : `TAP_IDLE;
      default:       tap_d = `TAP_RESET;
    endcase
  end

  // scan logic lives on the tester's clock; the pins are its own domain
  always @(posedge i_test_clk or negedge i_test_rst_b) begin
    if (!i_test_rst_b) begin
      tap_q       <= `TAP_RESET; // R2
      ir_q        <= `IR_RESET;
      ir_sh_q     <= `IR_CAPTURE;
      bypass_q    <= 1'b0;
      idcode_sh_q <= 4'h0;
    end else begin
      tap_q <= tap_d; // R3
      case (tap_q)
        `TAP_RESET:    ir_q    <= `IR_RESET;
        `TAP_CAP_IR:   ir_sh_q <= `IR_CAPTURE;
        `TAP_SHIFT_IR: ir_sh_q <= {i_test_din, ir_sh_q[3:1]}; // R4
        `TAP_UPD_IR:   ir_q    <= ir_sh_q;
        `TAP_CAP_DR: begin
          bypass_q    <= 1'b0;
          idcode_sh_q <= ir_q;
        end
        `TAP_SHIFT_DR: begin
          bypass_q    <= i_test_din; // R4
          idcode_sh_q <= {i_test_din, idcode_sh_q[3:1]};
        end
        default: ir_q <= ir_q;
      endcase
    end
  end

  assign shift_state = (tap_q == `TAP_SHIFT_IR) || (tap_q == `TAP_SHIFT_DR);

  always @* begin
    if (tap_q == `TAP_SHIFT_IR) begin
      tdo_bit = ir_sh_q[0];
    end else if (ir_q == `IR_BYPASS) begin
      tdo_bit = bypass_q;
    end else begin
      tdo_bit = idcode_sh_q[0];
    end
  end

  always @(negedge i_test_clk or negedge i_test_rst_b) begin
    if (!i_test_rst_b) begin
      o_test_dout    <= 1'b0;
      o_test_dout_oe <= 1'b0;
    end else begin
      o_test_dout    <= tdo_bit;                   // R5
      o_test_dout_oe <= shift_state && o_scan_mode; // R5 R6
    end
  end

  // ---------------- background debug serial port ----------------
  wire dev_serial_clock_lvl;
  wire dev_serial_clock_rise;
  reg  dsi_meta_q;
  reg  dsi_sync_q;
  reg  [16:0] rx_sh_q;
  reg  [16:0] tx_sh_q;
  reg  [4:0]  bit_cnt_q;

  level_sync u_dev_serial_clock_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_async   (i_dev_serial_clock),
    .o_level   (dev_serial_clock_lvl),
    .o_rise    (dev_serial_clock_rise),
    .o_fall    ()
  ); // R7

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dsi_meta_q       <= 1'b0;
      dsi_sync_q       <= 1'b0;
      rx_sh_q          <= 17'h00000;
      tx_sh_q          <= 17'h00000;
      bit_cnt_q        <= 5'h00;
      o_dev_serial_out <= 1'b0;
      o_rx_packet      <= 17'h00000;
      o_rx_valid       <= 1'b0;
    end else begin
      dsi_meta_q <= i_dev_serial_in;
      dsi_sync_q <= dsi_meta_q;
      o_rx_valid <= 1'b0;
      // packet rate is bounded by the debugger keeping the clock slow enough; R8
      if (dev_serial_clock_rise && !o_scan_mode) begin
        rx_sh_q          <= {rx_sh_q[15:0], dsi_sync_q};   // R9
        o_dev_serial_out <= tx_sh_q[16];                   // R9 R10
        if (bit_cnt_q == `BDM_CNT_LAST) begin
          bit_cnt_q   <= 5'h00;
          o_rx_packet <= {rx_sh_q[15:0], dsi_sync_q};
          o_rx_valid  <= 1'b1;
          tx_sh_q     <= i_tx_packet;
        end else begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
          tx_sh_q   <= {tx_sh_q[15:0], 1'b0};
        end
      end
    end
  end

  // ---------------- breakpoint handling ----------------
  reg breakpoint_request_meta_q;
  reg breakpoint_request_sync_q;
  reg breakpoint_request_prev_q;
  reg breakpoint_request_pend_q;

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      breakpoint_request_meta_q <= 1'b0;
      breakpoint_request_sync_q <= 1'b0;
      breakpoint_request_prev_q <= 1'b0;
      breakpoint_request_pend_q <= 1'b0;
      o_halt_req  <= 1'b0;
      o_debug_irq <= 1'b0;
    end else begin
      breakpoint_request_meta_q <= i_breakpoint_request;
      breakpoint_request_sync_q <= breakpoint_request_meta_q;
      breakpoint_request_prev_q <= breakpoint_request_sync_q;
      o_debug_irq <= 1'b0;
      if (breakpoint_request_sync_q && !breakpoint_request_prev_q) begin
        if (i_breakpoint_disable) begin
          o_debug_irq <= 1'b1; // R12
        end else begin
          breakpoint_request_pend_q <= 1'b1;
        end
      end
      // halt waits for the instruction in flight to retire
      if (breakpoint_request_pend_q && i_instr_done) begin
        o_halt_req  <= 1'b1; // R11
        breakpoint_request_pend_q <= 1'b0;
      end else if (!breakpoint_request_sync_q && !breakpoint_request_pend_q) begin
        o_halt_req <= 1'b0;
      end
    end
  end

  // ---------------- trace outputs ----------------
  wire [7:0] buf_in;
  wire [7:0] buf_out;
  wire       buf_valid;
  wire       buf_ready;
  reg  [1:0] div_q;
  reg        trace_run_q;
  wire       word_slot;
  wire       start_code;
  wire       drop_slot;
  wire [3:0] status_now;

  // halted core always reports the halt code
  assign status_now = o_halt_req ? `PST_HALT : i_core_status; // R11
  assign buf_in     = {status_now, i_core_debug_data};

  skid_buffer2 u_trace_buf (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_data    (buf_in),
    .i_valid   (i_core_data_valid),
    .o_ready   (o_core_data_ready),
    .o_data    (buf_out),
    .o_valid   (buf_valid),
    .i_ready   (buf_ready)
  );

  assign word_slot = (div_q == `TRC_DIV_LOAD) && trace_run_q && !i_trace_clock_disable;
  assign start_code = (buf_out[7:4] == `PST_RESET_C) || (buf_out[7:4] == `PST_RESET_D) ||
                      (buf_out[7:4] == `PST_HALT);
  // any status other than a start code ahead of it is popped so the buffer cannot wedge
  assign drop_slot  = !trace_run_q && buf_valid && !start_code && (div_q == `TRC_DIV_LOAD);
  assign buf_ready  = word_slot || drop_slot;

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_q             <= 2'h0;
      trace_run_q       <= 1'b0;
      o_trace_clock     <= 1'b0;
      o_proc_status_out <= `PST_NONE;
      o_debug_data_out  <= 4'h0;
    end else begin
      div_q <= div_q + 2'h1;
      // armed just before a load slot so the first rise shows the start word
      if (!trace_run_q && buf_valid && start_code && (div_q == `TRC_DIV_ARM)) begin
        trace_run_q <= 1'b1; // R15
      end else if (drop_slot) begin
        o_proc_status_out <= `PST_NONE;
      end
      // frozen outputs while disabled; the debugger must resync after
      if (trace_run_q && !i_trace_clock_disable) begin // R14
        if (word_slot && buf_valid) begin
          o_proc_status_out <= buf_out[7:4]; // R16
          o_debug_data_out  <= buf_out[3:0]; // R18
        end
        if (div_q == `TRC_DIV_RISE) begin
          o_trace_clock <= 1'b1; // R13
        end else if (div_q == `TRC_DIV_FALL) begin
          o_trace_clock <= 1'b0;
        end
      end
    end
  end

  assign o_all_status_and   = &o_proc_status_out; // R17
  // R19
  assign o_system_clock_out = o_trace_clock;

endmodule

`default_nettype wire

// File: verilog/debug_trace_port_defines.vh
`ifndef DEBUG_TRACE_PORT_DEFINES_VH
`define DEBUG_TRACE_PORT_DEFINES_VH

// test access port controller states
`define TAP_RESET      4'h0
`define TAP_IDLE       4'h1
`define TAP_SEL_DR     4'h2
`define TAP_CAP_DR     4'h3
`define TAP_SHIFT_DR   4'h4
`define TAP_EXIT1_DR   4'h5
`define TAP_PAUSE_DR   4'h6
`define TAP_EXIT2_DR   4'h7
`define TAP_UPD_DR     4'h8
`define TAP_SEL_IR     4'h9
`define TAP_CAP_IR     4'ha
`define TAP_SHIFT_IR   4'hb
`define TAP_EXIT1_IR   4'hc
`define TAP_PAUSE_IR   4'hd
`define TAP_EXIT2_IR   4'he
`define TAP_UPD_IR     4'hf

// instruction register
`define IR_WIDTH       4
`define IR_RESET       4'h1
`define IR_CAPTURE     4'h1
`define IR_BYPASS      4'hf

// processor status codes
`define PST_HALT       4'hf
`define PST_RESET_C    4'hc
`define PST_RESET_D    4'hd
`define PST_NONE       4'h0

// background debug serial packet
`define BDM_LEN        17
`define BDM_CNT_W      5
`define BDM_CNT_LAST   5'h10

// trace clock: four reference cycles per trace word
`define TRC_DIV_W      2
`define TRC_DIV_RISE   2'h2
`define TRC_DIV_FALL   2'h0
`define TRC_DIV_LOAD   2'h0
`define TRC_DIV_ARM    2'h3

// strap is taken once the two synchroniser flops hold the pin
`define STRAP_WAIT     2'h2

// buffer
`define BUF_W          8

`endif

// File: verilog/level_sync.v
`default_nettype none

// two-flop synchroniser with a two-sample agreement stage
module level_sync (
  input  wire i_ref_clk,
  input  wire i_rst_b,
  input  wire i_async,
  output reg  o_level,
  output wire o_rise,
  output wire o_fall
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      prev_q  <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
      // accept a new level only when two consecutive samples agree
      if (sync_q == prev_q) begin
        o_level <= sync_q;
      end
    end
  end

  assign o_rise = (sync_q == prev_q) && sync_q && !o_level;
  assign o_fall = (sync_q == prev_q) && !sync_q && o_level;

endmodule

`default_nettype wire

// File: verilog/skid_buffer2.v
`default_nettype none

// two-entry buffer with valid/ready on both sides
module skid_buffer2 (
  input  wire       i_ref_clk,
  input  wire       i_rst_b,
  input  wire [7:0] i_data,
  input  wire       i_valid,
  output wire       o_ready,
  output wire [7:0] o_data,
  output wire       o_valid,
  input  wire       i_ready
);

  reg [7:0] mem_q [0:1];
  reg       wr_q;
  reg       rd_q;
  reg [1:0] cnt_q;
  wire      push;
  wire      pop;

  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data  = mem_q[rd_q];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
    end else begin
      if (push) begin
        mem_q[wr_q] <= i_data;
        wr_q        <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

`default_nettype wire

// File: dv/debug_trace_port_checker.sv
`default_nettype none
module debug_trace_port_checker (
  // clock, resets and controls
  input wire logic       i_ref_clk,
  input wire logic       i_rst_b,
  input wire logic       i_test_rst_b,
  input wire logic       i_dev_serial_clock,
  input wire logic       i_breakpoint_request,
  input wire logic       i_breakpoint_disable,
  input wire logic       i_trace_clock_disable,
  input wire logic [3:0] i_core_status,
  input wire logic       i_core_data_valid,
  // watched outputs
  input wire logic       o_test_dout_oe,
  input wire logic       o_scan_mode,
  input wire logic       o_dev_serial_out,
  input wire logic       o_debug_irq,
  input wire logic       o_trace_clock,
  input wire logic [3:0] o_proc_status_out,
  input wire logic [3:0] o_debug_data_out,
  input wire logic       o_all_status_and,
  input wire logic       o_system_clock_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  logic seen_q;
  // conservative: set when a start code is only offered, not yet taken
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      seen_q <= 1'b0;
    else if (i_core_data_valid && i_core_status[3:2] == 2'b11 && i_core_status != 4'he)
      seen_q <= 1'b1;
  end
  sequence tcd_held;
    i_trace_clock_disable [*4];
  endsequence
  sequence trc_rise_free;
    $rose(o_trace_clock) ##0 !i_trace_clock_disable [*3];
  endsequence
  a_oe_scan_only: assert property (o_test_dout_oe |-> o_scan_mode)
    else $error("dout enable outside scan mode");
  a_oe_test_reset: assert property (!i_test_rst_b |-> !o_test_dout_oe)
    else $error("dout enable during test reset");
  a_all_and: assert property (o_all_status_and == &o_proc_status_out)
    else $error("combined status wrong");
  a_sysclk_copy: assert property (o_system_clock_out == o_trace_clock)
    else $error("system clock out differs");
  a_trace_start: assert property (!seen_q |-> !o_trace_clock)
    else $error("trace clock before start code");
  a_trace_shape: assert property (trc_rise_free |-> $fell(o_trace_clock))
    else $error("trace clock high time wrong");
  a_status_centre: assert property ($rose(o_trace_clock) |->
    $stable(o_proc_status_out) && $stable(o_debug_data_out) ##1 $stable(o_proc_status_out))
    else $error("status moves near trace clock rise");
  a_freeze_trace: assert property (tcd_held |-> $stable(o_trace_clock) && $stable(o_proc_status_out))
    else $error("trace pins move while disabled");
  a_breakpoint_request_irq: assert property ($rose(i_breakpoint_request) && i_breakpoint_disable
    |-> ##[1:8] o_debug_irq)
    else $error("no debug interrupt");
  a_serial_sync: assert property (!$stable(o_dev_serial_out)
    |-> $past(i_dev_serial_clock, 3) && $past(i_dev_serial_clock, 4))
    else $error("serial out moved without validated clock");
endmodule
bind debug_trace_port debug_trace_port_checker chk (
  .i_ref_clk, .i_rst_b, .i_test_rst_b, .i_dev_serial_clock, .i_breakpoint_request,
  .i_breakpoint_disable, .i_trace_clock_disable, .i_core_status, .i_core_data_valid,
  .o_test_dout_oe, .o_scan_mode, .o_dev_serial_out, .o_debug_irq, .o_trace_clock,
  .o_proc_status_out, .o_debug_data_out, .o_all_status_and, .o_system_clock_out
);
`default_nettype wire

// File: dv/debug_probe_model.sv
`default_nettype none
module debug_probe_model #(
  parameter int HALF_NS = 500
) (
  // serial link
  output var logic o_dev_serial_clock,
  output var logic o_dev_serial_in,
  input wire logic i_dev_serial_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_dev_serial_clock, o_dev_serial_in} = 2'b00;
  // 1 us period is at most a fifth of the trace rate; clock idles low
  task automatic xfer(input logic [16:0] pkt, output logic [16:0] got);
    for (int i = 16; i >= 0; i--) begin
      o_dev_serial_in = pkt[i];
      #(HALF_NS);
      o_dev_serial_clock = 1'b1;
      #(HALF_NS);
      got[i] = i_dev_serial_out;
      o_dev_serial_clock = 1'b0;
    end
    o_dev_serial_in = ~pkt[0];
  endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
`include "debug_trace_port_defines.vh"
`default_nettype none
`define CHK(nm, ex, sn) begin \
  cmp_count++; \
  if ((sn) !== (ex)) begin \
    err_count++; \
    $display("[FAIL] %s: expected %h seen %h", nm, ex, sn); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_ref_clk, i_rst_b, i_scan_select, i_test_rst_b, i_test_clk, i_test_mode;
  logic        i_test_din, i_breakpoint_request, i_instr_done, i_core_data_valid;
  logic        i_breakpoint_disable, i_trace_clock_disable, o_scan_mode;
  logic [3:0]  i_core_status, i_core_debug_data, o_proc_status_out, o_debug_data_out;
  logic [16:0] i_tx_packet, o_rx_packet, rx_q, got;
  logic        o_test_dout, o_test_dout_oe, o_dev_serial_out, o_core_data_ready, o_halt_req;
  logic        o_debug_irq, o_rx_valid, o_trace_clock, o_all_status_and, o_system_clock_out;
  wire logic   i_dev_serial_clock, i_dev_serial_in;
  logic [7:0]  trq[$];
  int          err_count, cmp_count, cyc, n, k, sz;
  debug_trace_port uut (
    .i_ref_clk, .i_rst_b, .i_scan_select, .i_test_rst_b, .i_test_clk, .i_test_mode,
    .i_test_din, .o_test_dout, .o_test_dout_oe, .i_dev_serial_clock, .i_dev_serial_in,
    .o_dev_serial_out, .i_breakpoint_request, .i_instr_done, .i_core_status,
    .i_core_debug_data, .i_core_data_valid, .o_core_data_ready, .o_halt_req, .o_debug_irq,
    .i_breakpoint_disable, .i_trace_clock_disable, .o_rx_packet, .o_rx_valid, .i_tx_packet,
    .o_trace_clock, .o_proc_status_out, .o_debug_data_out, .o_all_status_and,
    .o_system_clock_out, .o_scan_mode
  );
  debug_probe_model probe (
    .o_dev_serial_clock(i_dev_serial_clock),
    .o_dev_serial_in   (i_dev_serial_in),
    .i_dev_serial_out  (o_dev_serial_out)
  );
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      results();
    end
  end
  always @(posedge i_ref_clk) if (o_rx_valid === 1'b1) rx_q <= o_rx_packet;
  always @(posedge o_trace_clock) trq.push_back({o_proc_status_out, o_debug_data_out});
  task automatic results;
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset(input logic sel);
    i_scan_select = sel;
    i_rst_b = 1'b0;
    repeat (8) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    `CHK("scan mode", sel, o_scan_mode)
  endtask
  // valid stays up on return so back-to-back words need no gap
  task automatic push(input logic [7:0] w);
    {i_core_status, i_core_debug_data} = w;
    i_core_data_valid = 1'b1;
    n = 0;
    while (o_core_data_ready !== 1'b1 && n < 50) begin
      @(negedge i_ref_clk);
      n++;
    end
    `CHK("word taken", 1'b1, o_core_data_ready)
    @(negedge i_ref_clk);
  endtask
  task automatic tck(input logic [3:0] v);
    {i_test_mode, i_test_din} = v[3:2];
    #100;
    `CHK("dout enable", v[1], o_test_dout_oe)
    if (v[1]) `CHK("dout", v[0], o_test_dout)
    i_test_clk = 1'b1;
    #100;
    i_test_clk = 1'b0;
  endtask
  task automatic t_serial(input logic scan);
    i_tx_packet = 17'h1a5c3;
    rx_q = 17'h0;
    probe.xfer(17'h0b00f, got);
    `CHK("rx packet", scan ? 17'h0 : 17'h0b00f, rx_q)
    if (!scan) begin
      probe.xfer(17'h13579, got);
      `CHK("rx packet", 17'h13579, rx_q)
      `CHK("tx packet", 17'h1a5c3, got)
    end
  endtask
  task automatic t_trace;
    logic [7:0] w[4] = '{8'hca, 8'h35, 8'hf0, 8'h7e};
    repeat (20) @(negedge i_ref_clk);
    `CHK("idle trace clock", 1'b0, o_trace_clock)
    foreach (w[i]) push(w[i]);
    i_core_data_valid = 1'b0;
    repeat (30) @(negedge i_ref_clk);
    foreach (w[i]) `CHK("trace word", w[i], trq[i])
    i_trace_clock_disable = 1'b1;
    repeat (8) @(negedge i_ref_clk);
    sz = trq.size();
    {i_core_status, i_core_debug_data} = 8'h96;
    i_core_data_valid = 1'b1;
    k = 0;
    while (o_core_data_ready === 1'b1 && k < 9) begin
      @(negedge i_ref_clk);
      k++;
    end
    i_core_data_valid = 1'b0;
    repeat (20) @(negedge i_ref_clk);
    `CHK("frozen words", sz, trq.size())
    `CHK("buffer depth", 2, k)
    i_trace_clock_disable = 1'b0;
    repeat (30) @(negedge i_ref_clk);
    // one rise of the old word may come before the debugger resyncs
    `CHK("held word", 8'h96, trq[sz + 1])
    `CHK("held word", 8'h96, trq[sz + 2])
  endtask
  task automatic t_breakpoint_request;
    {i_breakpoint_disable, i_breakpoint_request} = 2'b11;
    k = 0;
    repeat (20) begin
      @(negedge i_ref_clk);
      if (o_debug_irq === 1'b1) k++;
    end
    `CHK("debug irq pulses", 1, k)
    `CHK("no halt", 1'b0, o_halt_req)
    {i_breakpoint_disable, i_breakpoint_request} = 2'b00;
    repeat (5) @(negedge i_ref_clk);
    i_breakpoint_request = 1'b1;
    repeat (10) @(negedge i_ref_clk);
    `CHK("halt before done", 1'b0, o_halt_req)
    i_instr_done = 1'b1;
    @(negedge i_ref_clk);
    i_instr_done = 1'b0;
    repeat (8) @(negedge i_ref_clk);
    `CHK("halted", 1'b1, o_halt_req)
    push(8'h13);
    i_core_data_valid = 1'b0;
    repeat (20) @(negedge i_ref_clk);
    `CHK("halt status", `PST_HALT, trq[$][7:4])
  endtask
  // {mode, din, expected enable, expected dout} sampled before each rise
  task automatic t_scan;
    logic [3:0] seq[17] = '{4'h0, 4'h8, 4'h8, 4'h0, 4'h0, 4'h7, 4'h6, 4'h6, 4'he,
                            4'h8, 4'h8, 4'h0, 4'h0, 4'h6, 4'h3, 4'ha, 4'h8};
    do_reset(1'b1);
    t_serial(1'b1);
    i_test_rst_b = 1'b1;
    foreach (seq[i]) tck(seq[i]);
    for (int i = 0; i < 6; i++) tck(seq[i]);
    i_test_rst_b = 1'b0;
    #20;
    `CHK("dout enable in test reset", 1'b0, o_test_dout_oe)
  endtask
  initial begin
    {i_rst_b, i_scan_select, i_test_rst_b, i_test_clk, i_test_mode, i_test_din} = 6'h0;
    {i_breakpoint_request, i_instr_done, i_core_data_valid} = 3'h0;
    {i_breakpoint_disable, i_trace_clock_disable} = 2'h0;
    {i_core_status, i_core_debug_data} = 8'h0;
    i_tx_packet = 17'h0;
    rx_q = 17'h0;
    @(negedge i_ref_clk);
    do_reset(1'b0);
    t_serial(1'b0);
    t_trace;
    t_breakpoint_request;
    t_scan;
    results();
  end
endmodule
`default_nettype wire
